// ==== logic/mbp_port.sv ====
// processor bus port with strobe decode, fifo override and handshake pins
`timescale 1ns/1ps
// Function
// - separate-strobe mode latches muxed address on address strobe falling edge
// - separate-strobe mode honours read/write strobes only while qualifier high
// - read strobe low makes the device drive register data on the bus
// - write strobe low makes the device accept data into selected register
// - strobe-direction mode latches muxed address with active-low address strobe
// - strobe-direction mode honours data strobe only while qualifier low
// - data strobe with direction high reads, direction low writes
// - strobe style input high selects strobe-plus-direction mode
// - enable, ack, qualifier and strobe together force access to fifo port
// - wide flag open-drain, asserts on 16-bit fifo access when host enabled
// - fifo request asserts when fifo needs or holds a byte, clears on access
// - wait-ready deasserts on fifo access with no data or no room
// - address enable input overrides address bits, defaults asserted
// - active-low ack forces chip select, defaults deasserted
// - strobe style input low selects separate-strobe mode
// - mux select high takes address from bus, low uses dedicated pins
// - three polarity inputs set compare level of the upper address bits
module mbp_port
  import mbp_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        strobe_style_select,
  input  wire logic        bus_mux_select,
  input  wire logic [2:0]  sel_polarity_b,
  input  wire logic        addr_latch_strobe,
  input  wire logic        space_qualifier,
  input  wire logic        read_or_data_strobe_b,
  input  wire logic        write_or_direction,
  input  wire logic        cpu_addr_override,
  input  wire logic        cpu_ack_select_b,
  input  wire logic        wide_request,
  input  wire logic [7:0]  ad_in,
  output logic      [7:0]  ad_out,
  output logic             ad_oe,
  input  wire logic [4:0]  addr_pins,
  input  wire logic [7:0]  ad_hi_in,
  input  wire logic [1:0]  pin_enable,
  output mbp_req_s         req_data,
  output logic             req_valid,
  input  wire logic        req_ready,
  input  wire logic [7:0]  rd_data,
  input  wire logic        fifo_has_byte,
  input  wire logic        fifo_has_room,
  input  wire logic        fifo_wants_cpu,
  output logic             wide_access_flag_out,
  output logic             wide_access_flag_oe,
  output logic             host_wait_ready_out,
  output logic             host_wait_ready_oe,
  output logic             fifo_req_out,
  output logic             fifo_req_oe
);

  // ----------------------------------------------------------------
  // pin synchronisers: three stages, change counts when 2nd == 3rd
  // ----------------------------------------------------------------
  localparam int NS = 6;
  logic [NS-1:0] raw_in;
  logic [NS-1:0] s1;
  logic [NS-1:0] s2;
  logic [NS-1:0] s3;
  logic [NS-1:0] flt;
  logic [7:0]    ad_s1;
  logic [7:0]    ad_s2;

  assign raw_in = {addr_latch_strobe, space_qualifier, read_or_data_strobe_b,
                   write_or_direction, cpu_addr_override, cpu_ack_select_b};

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      s1  <= 6'h3f;
      s2  <= 6'h3f;
      s3  <= 6'h3f;
      flt <= 6'h3f;
    end else begin
      s1  <= raw_in;
      s2  <= s1;
      s3  <= s2;
      flt <= (s2 & s3) | (flt & (s2 ^ s3));
    end
  end

  // address and data are sampled two deep; they settle long before strobes
  always_ff @(posedge sys_clk) begin
    ad_s1 <= ad_in;
    ad_s2 <= ad_s1;
  end

  wire als      = flt[5];
  wire spq      = flt[4];
  wire rds_b    = flt[3];
  wire wrd      = flt[2];
  wire aen      = flt[1];
  wire ack_b    = flt[0];

  // ----------------------------------------------------------------
  // strobe decode by mode
  // ----------------------------------------------------------------
  logic       als_d;
  logic [4:0] addr_lat;
  wire        als_fall  = als_d & ~als;
  wire        mode_dir  = strobe_style_select;
  wire        rd_sep    = ~rds_b & spq;
  wire        wr_sep    = ~wrd & spq;
  wire        ds_ok     = ~rds_b & ~spq;
  wire        rd_dir    = ds_ok & wrd;
  wire        wr_dir    = ds_ok & ~wrd;
  wire        rd_act    = mode_dir ? rd_dir : rd_sep;
  wire        wr_act    = mode_dir ? wr_dir : wr_sep;
  wire        any_act   = rd_act | wr_act;

  // chip select: upper muxed bits xor against polarity pins
  wire [2:0]  hi_bits   = ad_hi_in[7:5];
  wire        cs_mux    = (hi_bits == ~sel_polarity_b);
  wire [4:0]  base_addr = bus_mux_select ? addr_lat : addr_pins;
  wire        cs_base   = bus_mux_select ? cs_mux : 1'b1;
  wire        spq_ok    = mode_dir ? ~spq : spq;
  wire        force_fifo = aen & ~ack_b & spq_ok & any_act;
  wire        cs        = cs_base | ~ack_b;
  wire [4:0]  eff_addr  = force_fifo ? MBP_FIFO_REG : base_addr;
  wire        fifo_hit  = any_act & cs & (eff_addr == MBP_FIFO_REG);

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      als_d    <= 1'b1;
      addr_lat <= MBP_ADDR_RST;
    end else begin
      als_d <= als;
      // latches on falling edge; active-low strobe, same edge
      if (als_fall) begin
        addr_lat <= ad_s2[4:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // access sequencer and two-entry write buffer
  // ----------------------------------------------------------------
  mbp_state_e state;
  mbp_state_e next_state;
  mbp_req_s   buf0;
  mbp_req_s   buf1;
  logic [1:0] cnt;
  logic [1:0] next_cnt;
  wire        start   = (state == MBP_IDLE) & any_act & cs;
  wire        do_push = start & wr_act & (cnt != 2'd2);
  wire        do_pop  = req_valid & req_ready;
  wire        stall   = start & wr_act & (cnt == 2'd2);
  mbp_req_s   new_req;

  assign next_cnt = cnt + {1'b0, do_push} - {1'b0, do_pop};

  assign new_req = '{write: 1'b1, wide: wide_request & fifo_hit,
                     addr: eff_addr, data: ad_s2};

  always_comb begin
    next_state = state;
    unique case (state)
      MBP_IDLE: if (start && !stall) next_state = MBP_ACT;
      MBP_ACT:  next_state = MBP_HOLD;
      MBP_HOLD: if (!any_act) next_state = MBP_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state <= MBP_IDLE;
      cnt   <= 2'd0;
      req_valid <= 1'b0;
      buf0  <= '0;
      buf1  <= '0;
    end else begin
      state <= next_state;
      if (do_pop) begin
        buf0 <= (cnt == 2'd2 || (do_push && cnt == 2'd1)) ?
                (cnt == 2'd2 ? buf1 : new_req) : buf0;
      end else if (do_push && cnt == 2'd0) begin
        buf0 <= new_req;
      end
      if (do_push && ((cnt == 2'd1 && !do_pop) || (cnt == 2'd2 && do_pop)))
        buf1 <= new_req;
      cnt       <= next_cnt;
      req_valid <= (next_cnt != 2'd0);
    end
  end

  assign req_data  = buf0;

  // ----------------------------------------------------------------
  // read data drive and handshake pins
  // ----------------------------------------------------------------
  wire host_en = pin_enable[0];
  wire frdy_en = pin_enable[1];
  wire not_ready = fifo_hit & (rd_act ? ~fifo_has_byte : ~fifo_has_room);
  wire wide_now  = fifo_hit & wide_request;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ad_out               <= MBP_RD_RST;
      ad_oe                <= 1'b0;
      wide_access_flag_out <= 1'b0;
      wide_access_flag_oe  <= 1'b0;
      host_wait_ready_out  <= 1'b0;
      host_wait_ready_oe   <= 1'b0;
      fifo_req_out         <= 1'b0;
      fifo_req_oe          <= 1'b0;
    end else begin
      ad_out <= rd_data;
      ad_oe  <= rd_act & cs;
      wide_access_flag_oe  <= host_en & wide_now;
      host_wait_ready_oe   <= host_en & (not_ready | stall);
      fifo_req_oe          <= frdy_en;
      if (fifo_hit)
        fifo_req_out <= 1'b0;
      else
        fifo_req_out <= frdy_en & fifo_wants_cpu;
    end
  end

endmodule

// ==== logic/mbp_pkg.sv ====
// package: constants and carrier types for the processor bus port
package mbp_pkg;
  localparam int          MBP_AW        = 5;
  localparam int          MBP_DW        = 8;
  localparam logic [4:0]  MBP_FIFO_REG  = 5'h0c;
  localparam int          MBP_EN_HOST   = 0;
  localparam int          MBP_EN_FRDY   = 2;
  localparam logic [7:0]  MBP_RD_RST    = 8'h00;
  localparam logic [4:0]  MBP_ADDR_RST  = 5'h00;

  typedef enum logic [1:0] {
    MBP_IDLE = 2'b00,
    MBP_ACT  = 2'b01,
    MBP_HOLD = 2'b11
  } mbp_state_e;

  typedef struct packed {
    logic       write;
    logic       wide;
    logic [4:0] addr;
    logic [7:0] data;
  } mbp_req_s;
endpackage

// ==== verification/mbp_port_assertions.sv ====
// checker: port properties of the bus port
`timescale 1ns/1ps
module mbp_port_chk
  import mbp_pkg::*;
(
  input wire logic       sys_clk, rst_b, strobe_style_select, ad_oe,
  input wire logic       space_qualifier, read_or_data_strobe_b,
  input wire logic       write_or_direction, req_valid, req_ready,
  input wire logic       fifo_req_oe, host_wait_ready_out,
  input wire logic       host_wait_ready_oe, wide_access_flag_out,
  input wire logic       wide_access_flag_oe,
  input wire logic [1:0] pin_enable,
  input wire logic [7:0] rd_data, ad_out,
  input wire mbp_req_s   req_data
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence rd_go; $rose(ad_oe); endsequence
  od_drive_a: assert property (!wide_access_flag_out && !host_wait_ready_out)
    else $error("open drain driven high");
  req_oe_a: assert property (fifo_req_oe == $past(pin_enable[1]))
    else $error("fifo request enable wrong");
  pins_off_a: assert property (!pin_enable[0] [*2] |->
    !host_wait_ready_oe && !wide_access_flag_oe) else $error("pins not off");
  sep_qual_a: assert property (rd_go and !strobe_style_select |->
    space_qualifier && !read_or_data_strobe_b) else $error("bad read");
  dir_qual_a: assert property (rd_go and strobe_style_select |->
    !space_qualifier && write_or_direction) else $error("bad dir read");
  rd_data_a: assert property (rd_go |-> ad_out == $past(rd_data))
    else $error("read data wrong");
  rd_end_a: assert property ($rose(read_or_data_strobe_b) |-> ##[0:6] !ad_oe)
    else $error("drive held");
  buf_hold_a: assert property (req_valid && !req_ready |=>
    req_valid && $stable(req_data)) else $error("queued word lost");
  wait_en_a: assert property ($rose(host_wait_ready_oe) |->
    pin_enable[0] || $past(pin_enable[0])) else $error("wait not enabled");
endmodule
bind mbp_port mbp_port_chk u_chk (.*);

// ==== verification/mbp_cpu_model.sv ====
// partner: processor bus master with wait-state stretch
`timescale 1ns/1ps
module mbp_cpu_model (
  input wire logic       sys_clk, strobe_style_select, ad_oe,
  input wire logic       host_wait_ready_oe,
  input wire logic [7:0] ad_out,
  output logic           addr_latch_strobe, read_or_data_strobe_b,
  output logic           write_or_direction,
  output logic [7:0]     ad_in,
  output logic [4:0]     addr_pins
);
  initial {addr_latch_strobe, read_or_data_strobe_b} = 2'h1;
  initial {write_or_direction, ad_in, addr_pins} = 14'h2000;
  task automatic acc(input logic w, input logic [4:0] a,
                     input logic [7:0] d, output logic [7:0] r);
    int n, t;
    r = 8'h0;
    @(negedge sys_clk);
    addr_pins = a;
    ad_in = {3'h0, a ^ 5'h10};
    addr_latch_strobe = 1'h1;
    repeat (3) @(negedge sys_clk);
    addr_latch_strobe = 1'h0;
    // address must outlast the strobe filter and the latch
    repeat (6) @(negedge sys_clk);
    ad_in = d;
    write_or_direction = !w;
    read_or_data_strobe_b = w && !strobe_style_select;
    for (n = 0; n < 8 && t < 300; n++) begin
      @(negedge sys_clk);
      t++;
      if (ad_oe) r = ad_out;
      if (host_wait_ready_oe) n = 0;
    end
    @(negedge sys_clk);
    {read_or_data_strobe_b, write_or_direction} = 2'h3;
    ad_in = ~d;
    addr_latch_strobe = 1'h1;
    repeat (4) @(negedge sys_clk);
  endtask
endmodule

// ==== verification/testbench.sv ====
// testbench: processor access sequences against the bus port
`timescale 1ns/1ps
module testbench;
  import mbp_pkg::*;
  logic sys_clk = 0, rst_b = 0, strobe_style_select = 0, bus_mux_select = 0;
  logic space_qualifier = 1, cpu_addr_override = 1, cpu_ack_select_b = 1;
  logic wide_request = 0, req_ready = 1, fifo_has_byte = 1, saw_wait = 0;
  logic saw_wide = 0;
  logic fifo_has_room = 1, fifo_wants_cpu = 0, ad_oe, req_valid;
  logic addr_latch_strobe, read_or_data_strobe_b, write_or_direction;
  logic wide_access_flag_out, wide_access_flag_oe, host_wait_ready_out;
  logic host_wait_ready_oe, fifo_req_out, fifo_req_oe;
  logic [2:0] sel_polarity_b = 3'h7;
  logic [1:0] pin_enable = 2'h0;
  logic [7:0] ad_in, ad_out, ad_hi_in = 8'h0, rd_data = 8'h0, r;
  logic [4:0] addr_pins;
  mbp_req_s   req_data, q[$];
  int         failures = 0, check_count = 0;
  always #5 sys_clk = ~sys_clk;
  mbp_port dut (.*);
  mbp_cpu_model cpu (.*);
  always @(posedge sys_clk) begin
    if (req_valid && req_ready) q.push_back(req_data);
    if (host_wait_ready_oe) saw_wait <= 1'h1;
    if (wide_access_flag_oe) saw_wide <= 1'h1;
  end
  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'h1) begin
      failures++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic wr(input logic [4:0] a, ea, input logic [7:0] d,
                    input logic n);
    cpu.acc(1'h1, a, d, r);
    chk(q.size() == n, "write count");
    if (n) chk(q.pop_front() === {2'h2, ea, d}, "write word");
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e, x);
    rd_data = e;
    cpu.acc(1'h0, a, 8'h0, r);
    chk(r === x, "read data");
  endtask
  task automatic tally_and_finish();
    $display("failures=%0d checks=%0d", failures, check_count);
    if (failures == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge sys_clk);
    rst_b = 1;
    repeat (4) @(negedge sys_clk);
    wr(5'h03, 5'h03, 8'ha5, 1);
    rd(5'h03, 8'h3c, 8'h3c);
    space_qualifier = 0;
    wr(5'h03, 5'h03, 8'h11, 0);
    rd(5'h03, 8'h22, 8'h00);
    strobe_style_select = 1;
    wr(5'h07, 5'h07, 8'h5a, 1);
    rd(5'h07, 8'hc3, 8'hc3);
    space_qualifier = 1;
    wr(5'h07, 5'h07, 8'h33, 0);
    strobe_style_select = 0;
    bus_mux_select = 1;
    wr(5'h09, 5'h19, 8'h96, 1);
    sel_polarity_b = 3'h6;
    wr(5'h09, 5'h19, 8'h69, 0);
    cpu_ack_select_b = 0;
    wr(5'h05, MBP_FIFO_REG, 8'h0f, 1);
    req_ready = 0;
    cpu.acc(1'h1, 5'h01, 8'h01, r);
    cpu.acc(1'h1, 5'h02, 8'h02, r);
    req_ready = 1;
    repeat (4) @(negedge sys_clk);
    chk(q.size() == 2 && q[1].data === 8'h02, "stalled words");
    q = {};
    pin_enable = 2'h3;
    fifo_has_byte = 0;
    wide_request = 1;
    fork
      rd(5'h0c, 8'h44, 8'h44);
      begin
        repeat (20) @(negedge sys_clk);
        fifo_has_byte = 1;
      end
    join
    chk(saw_wait === 1'h1 && fifo_req_oe === 1'h1, "wait pins");
    chk(saw_wide === 1'h1, "wide flag");
    wide_request = 0;
    fifo_wants_cpu = 1;
    repeat (3) @(negedge sys_clk);
    chk(fifo_req_out === 1'h1, "fifo request");
    tally_and_finish();
  end
  initial begin
    #200000;
    failures++;
    tally_and_finish();
  end
endmodule
